/* host_model.sv */
`timescale 1ns/1ps
module host_model
    import pll_status_regs_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register strobe port
    output logic [ADDR_W-1:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid
);
    initial begin
        regAddr = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = 8'h00;
    end

    // Idle lines carry the inverse of the last request so that stale values never match.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        n = 0;
        #1;
        while (regRdValid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = (regRdValid === 1'b1) && (n == 0);
        d = regRdData;
    endtask
endmodule

/* pll_status_and_output_format_regs.sv */
`timescale 1ns/1ps
module pll_status_and_output_format_regs
    import pll_status_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register access from the serial control port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Status sources from the PLL and monitors
    input wire status_src_s statusIn,
    // Decoded controls for the first clock output
    output out_ctrl_s outCtrl
);

    // ==========================================================
    // Status synchronisers
    // ==========================================================
    // The sources come from other clock domains, so each passes two flops.
    status_src_s statusMeta;
    status_src_s statusSync;

    always_ff @(posedge clk) begin
        if (srst) begin
            statusMeta <= '0;
            statusSync <= '0;
        end else begin
            statusMeta <= statusIn;
            statusSync <= statusMeta;
        end
    end

    logic [7:0] statusWord;

    always_comb begin
        statusWord = STATUS_RESET;
        statusWord[ST_HOLDOVER_BIT] = statusSync.holdoverActive;
        statusWord[ST_SECOND_REF_SEL_BIT] = statusSync.secondRefSelected;
        statusWord[ST_VCO_THR_BIT] = statusSync.vcoAboveThreshold;
        statusWord[ST_SECOND_REF_THR_BIT] = statusSync.secondRefAboveThreshold;
        statusWord[ST_FIRST_REF_THR_BIT] = statusSync.firstRefAboveThreshold;
        statusWord[ST_LOCK_BIT] = statusSync.digitalLock;
    end

    // ==========================================================
    // Output control register
    // ==========================================================
    logic [7:0] firstOutCtrl;

    always_ff @(posedge clk) begin
        if (srst) begin
            firstOutCtrl <= FIRST_OUT_CTRL_RESET;
        end else if (regWrite && regAddr == FIRST_OUT_CTRL_ADDR) begin
            firstOutCtrl <= regWrData;
        end
    end

    // ==========================================================
    // Read port
    // ==========================================================
    // Writes to the status address fall through here and change nothing.
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (!regRead) begin
                regRdData <= 8'h00;
            end else if (regAddr == STATUS_ADDR) begin
                regRdData <= statusWord;
            end else if (regAddr == FIRST_OUT_CTRL_ADDR) begin
                regRdData <= firstOutCtrl;
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

    // ==========================================================
    // Output driver decode
    // ==========================================================
    out_ctrl_s next_outCtrl;
    out_format_e fmt;
    logic [1:0] pol;
    logic [1:0] legEn;

    always_comb begin
        fmt = out_format_e'(firstOutCtrl[OC_FORMAT_BIT]);
        pol = firstOutCtrl[OC_POL_HI:OC_POL_LO];
        legEn = firstOutCtrl[OC_LEG_EN_HI:OC_LEG_EN_LO];
        next_outCtrl = '0;
        next_outCtrl.singleEnded = (fmt == FMT_SINGLE);
        next_outCtrl.diffSwing = firstOutCtrl[OC_SWING_HI:OC_SWING_LO];
        case (fmt)
            FMT_SINGLE: begin
                next_outCtrl.legAEnable = legEn[0];
                next_outCtrl.legBEnable = legEn[1];
                case (pol)
                    2'b00: begin
                        next_outCtrl.legAInvert = 1'b0;
                        next_outCtrl.legBInvert = 1'b0;
                    end
                    2'b01: begin
                        next_outCtrl.legAInvert = 1'b1;
                        next_outCtrl.legBInvert = 1'b1;
                    end
                    2'b10: begin
                        next_outCtrl.legAInvert = 1'b0;
                        next_outCtrl.legBInvert = 1'b1;
                    end
                    default: begin
                        next_outCtrl.legAInvert = 1'b1;
                        next_outCtrl.legBInvert = 1'b0;
                    end
                endcase
            end
            default: begin
                // The differential pair is complementary; bit 3 swaps it.
                next_outCtrl.diffEnable = !firstOutCtrl[OC_PDOWN_BIT];
                next_outCtrl.legAInvert = pol[0];
                next_outCtrl.legBInvert = !pol[0];
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            outCtrl <= '0;
        end else begin
            outCtrl <= next_outCtrl;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_HOLDOVER_READ: assert property (
        regRead && regAddr == STATUS_ADDR |=>
            regRdData[ST_HOLDOVER_BIT] == $past(statusSync.holdoverActive))
        else $error("Holdover bit does not follow the live state.");

    AST_SECOND_REF_SEL_READ: assert property (
        regRead && regAddr == STATUS_ADDR |=>
            regRdData[ST_SECOND_REF_SEL_BIT] == $past(statusSync.secondRefSelected))
        else $error("Reference select bit is wrong.");

    AST_VCO_THR_READ: assert property (
        regRead && regAddr == STATUS_ADDR |=>
            regRdData[ST_VCO_THR_BIT] == $past(statusSync.vcoAboveThreshold))
        else $error("Oscillator threshold bit is wrong.");

    AST_SECOND_REF_THR_READ: assert property (
        regRead && regAddr == STATUS_ADDR |=>
            regRdData[ST_SECOND_REF_THR_BIT] == $past(statusSync.secondRefAboveThreshold))
        else $error("Second reference threshold bit is wrong.");

    AST_FIRST_REF_THR_READ: assert property (
        regRead && regAddr == STATUS_ADDR |=>
            regRdData[ST_FIRST_REF_THR_BIT] == $past(statusSync.firstRefAboveThreshold))
        else $error("First reference threshold bit is wrong.");

    AST_LOCK_PATH: assert property (
        $changed(statusIn.digitalLock) ##2 regRead && regAddr == STATUS_ADDR |=>
            regRdData[ST_LOCK_BIT] == $past(statusIn.digitalLock, 3))
        else $error("Lock bit does not reach the read data in three cycles.");

    AST_FORMAT_SELECT: assert property (
        regWrite && regAddr == FIRST_OUT_CTRL_ADDR ##1 !regWrite [*1] |=>
            outCtrl.singleEnded == $past(regWrData[OC_FORMAT_BIT], 2))
        else $error("Format select does not follow the written bit.");

    AST_LEG_GATING: assert property (
        // The decode lags the register by one cycle, so compare with the prior value.
        firstOutCtrl[OC_FORMAT_BIT] && $stable(firstOutCtrl) |=>
            outCtrl.legAEnable == $past(firstOutCtrl[OC_LEG_EN_LO]) &&
            outCtrl.legBEnable == $past(firstOutCtrl[OC_LEG_EN_HI]))
        else $error("Single-ended legs not gated by the enable field.");

    AST_DIFF_LEGS_OFF: assert property (
        !firstOutCtrl[OC_FORMAT_BIT] && $stable(firstOutCtrl) |=>
            !outCtrl.legAEnable && !outCtrl.legBEnable &&
            outCtrl.legAInvert != outCtrl.legBInvert)
        else $error("Differential mode legs not complementary.");

    AST_SE_POLARITY: assert property (
        firstOutCtrl[OC_FORMAT_BIT] && firstOutCtrl[OC_POL_HI:OC_POL_LO] == 2'b10 &&
            $stable(firstOutCtrl) |=> !outCtrl.legAInvert && outCtrl.legBInvert)
        else $error("Single-ended polarity code 10 mapped wrongly.");

    AST_POWER_DOWN: assert property (
        firstOutCtrl[OC_PDOWN_BIT] && $stable(firstOutCtrl) |=> !outCtrl.diffEnable)
        else $error("Differential driver enabled while powered down.");

    AST_STATUS_WRITE_IGNORED: assert property (
        regWrite && regAddr == STATUS_ADDR |=> $stable(firstOutCtrl))
        else $error("Status write disturbed the control register.");

    COV_STATUS_READ: cover property (
        regRead && regAddr == STATUS_ADDR ##1 regRdData[ST_LOCK_BIT]);
    COV_SINGLE_ENDED: cover property (outCtrl.singleEnded && outCtrl.legAInvert);
    COV_POWER_DOWN: cover property (
        $fell(outCtrl.diffEnable) && !outCtrl.singleEnded);

endmodule

/* pll_status_regs_pkg.sv */
package pll_status_regs_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 10'h1F;
    localparam logic [ADDR_W-1:0] FIRST_OUT_CTRL_ADDR = 10'hF0;

    // ==========================================================
    // Status register field positions
    // ==========================================================
    localparam int ST_HOLDOVER_BIT = 5;
    localparam int ST_SECOND_REF_SEL_BIT = 4;
    localparam int ST_VCO_THR_BIT = 3;
    localparam int ST_SECOND_REF_THR_BIT = 2;
    localparam int ST_FIRST_REF_THR_BIT = 1;
    localparam int ST_LOCK_BIT = 0;

    // ==========================================================
    // Output control field positions and reset value
    // ==========================================================
    localparam int OC_FORMAT_BIT = 7;
    localparam int OC_LEG_EN_HI = 6;
    localparam int OC_LEG_EN_LO = 5;
    localparam int OC_POL_HI = 4;
    localparam int OC_POL_LO = 3;
    localparam int OC_SWING_HI = 2;
    localparam int OC_SWING_LO = 1;
    localparam int OC_PDOWN_BIT = 0;
    localparam logic [7:0] FIRST_OUT_CTRL_RESET = 8'h62;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Live status sources as they arrive at the block.
    typedef struct packed {
        logic holdoverActive;
        logic secondRefSelected;
        logic vcoAboveThreshold;
        logic secondRefAboveThreshold;
        logic firstRefAboveThreshold;
        logic digitalLock;
    } status_src_s;

    // Decoded drive controls for the first clock output.
    typedef struct packed {
        logic singleEnded;
        logic diffEnable;
        logic [1:0] diffSwing;
        logic legAEnable;
        logic legBEnable;
        logic legAInvert;
        logic legBInvert;
    } out_ctrl_s;

    // Output formats selected by the format bit.
    typedef enum logic [0:0] {
        FMT_DIFF = 1'b0,
        FMT_SINGLE = 1'b1
    } out_format_e;

endpackage

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import pll_status_regs_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] regAddr;
    logic regWrite;
    logic regRead;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic regRdValid;
    status_src_s statusIn = '0;
    out_ctrl_s outCtrl;
    int fails = 0;
    int numChecks = 0;
    logic [7:0] rdat;
    logic [7:0] d;
    logic [5:0] v;
    logic ok;

    always #2.5 clk = ~clk;

    pll_status_and_output_format_regs u_pll_status_and_output_format_regs (
        .clk(clk), .srst(srst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .statusIn(statusIn), .outCtrl(outCtrl));

    host_model u_host_model (
        .clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

    // ==========================================================
    // Checking helpers
    // ==========================================================
    task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Expected drive controls for a control register value.
    function automatic out_ctrl_s dec(input logic [7:0] c);
        out_ctrl_s o;
        o.singleEnded = c[7];
        o.diffEnable = !c[7] && !c[0];
        o.diffSwing = c[2:1];
        o.legAEnable = c[7] && c[5];
        o.legBEnable = c[7] && c[6];
        o.legAInvert = c[3];
        o.legBInvert = c[7] ? (c[3] ^ c[4]) : !c[3];
        return o;
    endfunction

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
        u_host_model.rd(a, rdat, ok);
        check({9'h000, ok}, 10'h001, "read latency");
        check({2'b00, rdat}, {2'b00, exp}, what);
    endtask

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check(outCtrl, dec(8'h62), "reset decode");
        rd_chk(FIRST_OUT_CTRL_ADDR, 8'h62, "control reset");
        $display("Test reset done");
        for (int k = 0; k < 64; k++) begin
            d = {k[5:1], k[0], ~k[0], k[0]};
            u_host_model.wr(FIRST_OUT_CTRL_ADDR, d);
            repeat (2) @(posedge clk);
            #1;
            check(outCtrl, dec(d), "control decode");
            rd_chk(FIRST_OUT_CTRL_ADDR, d, "control readback");
        end
        $display("Test control done");
        for (int i = 0; i < 8; i++) begin
            v = (i < 6) ? 6'(1 << i) : ((i == 6) ? 6'h3F : 6'h00);
            @(posedge clk);
            statusIn <= v;
            // The read strobe lands two cycles after the change, the tightest spacing.
            @(posedge clk);
            rd_chk(STATUS_ADDR, {2'b00, v}, "status");
        end
        @(posedge clk);
        statusIn <= 6'h15;
        u_host_model.wr(STATUS_ADDR, 8'hFF);
        repeat (2) @(posedge clk);
        rd_chk(STATUS_ADDR, 8'h15, "status after write");
        rd_chk(FIRST_OUT_CTRL_ADDR, d, "control after status write");
        $display("Test status done");
        u_host_model.wr(10'h2F0, 8'h00);
        rd_chk(FIRST_OUT_CTRL_ADDR, d, "control after alias write");
        rd_chk(10'h2F0, 8'h00, "unmapped read");
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd_chk(FIRST_OUT_CTRL_ADDR, 8'h62, "control after reset");
        check(outCtrl, dec(8'h62), "decode after reset");
        $display("Test unmapped and reset done");
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("Error at %0t: run did not finish", $time);
        stop_test();
    end
endmodule
